// [core/msb_map.svh]
// Offsets, widths, field positions and reset values for the micro sequencer block.
`ifndef MSB_MAP_SVH
`define MSB_MAP_SVH
`define MSB_WORD_W 16
`define MSB_PC_W 18
`define MSB_ADDR_W 24
`define MSB_PC_SHIFT 4
`define MSB_BRANCH_W 12
`define MSB_OPLEN_MAX 5'h18
`define MSB_SIZE_LOW_ZERO 16
`define MSB_MEM_SIZE_DEFAULT 24'h010000
// Register select codes on the documented source/destination port.
`define MSB_SEL_MIH 4'h0
`define MSB_SEL_PC 4'h1
`define MSB_SEL_LOWER 4'h2
`define MSB_SEL_UPPER 4'h3
`define MSB_SEL_CASS 4'h4
`define MSB_SEL_SIZE 4'h5
`define MSB_SEL_NIB1 4'h6
`define MSB_SEL_NIB2 4'h7
`define MSB_SEL_INTR 4'h8
`define MSB_SEL_MERR 4'h9
`define MSB_SEL_PAR 4'hA
`define MSB_SEL_CARRY 4'hB
// Bit positions in the memory error nibble.
`define MSB_MERR_RDERR 0
`define MSB_MERR_OVR 1
`define MSB_MERR_RDOOB 2
`define MSB_MERR_WROOB 3
// Parallelism control field positions.
`define MSB_PAR_CARRY 7
`define MSB_PAR_UNIT_HI 6
`define MSB_PAR_UNIT_LO 5
`define MSB_PAR_LEN_HI 4
`define MSB_RESET_PAR 8'h00
`endif

// [core/msb_pkg.sv]
// Types shared by the micro sequencer block.
package msb_pkg;
  typedef enum logic [2:0] {
    MSB_OP_NONE,
    MSB_OP_BRANCH_FWD,
    MSB_OP_BIAS,
    MSB_OP_SET_CARRY,
    MSB_OP_CASS_STOP,
    MSB_OP_CASS_START
  } msb_op_t;
  typedef enum logic [1:0] {
    MSB_MEM_IDLE,
    MSB_MEM_READ,
    MSB_MEM_WRITE,
    MSB_MEM_SWAP
  } msb_mem_t;
  typedef enum {
    MSB_FETCH_MEM,
    MSB_FETCH_TAPE_WAIT
  } msb_fetch_t;
endpackage : msb_pkg

// [core/msb_sequencer.sv]
// Micro sequencer with instruction hold, program counter, bounds check and control group.
// What this block does
// RQ1: Hold 16-bit microinstruction plus odd parity; its decode steers control flow.
// RQ2: Outside tape mode, writes to instruction hold OR into the next fetched word.
// RQ3: Branch forward skips low twelve bits worth of words past the next word.
// RQ4: 18-bit program counter auto-increments in run, branches, wraps, readable and writable.
// RQ5: Counter reads shifted left four; writes drop four low bits; adder unaffected.
// RQ6: Memory references check 24-bit field address inclusively against lower and upper bound.
// RQ7: Failed check sets read flag on reads, write flag on writes or swaps.
// RQ8: Out-of-bounds reads proceed; writes or swaps need the override flag.
// RQ9: Only the starting field address is checked, never the field's length.
// RQ10: References below zero or above installed size set memory range error flag.
// RQ11: Read-only cassette register; run-mode reads stall until sixteen bits; overrun lost silently.
// RQ12: Tape mode executes each cassette word unless it was consumed as source data.
// RQ13: Tape mode branches still move the counter, but fetch stays on cassette.
// RQ14: Tape mode writes to instruction hold also OR into the next cassette word.
// RQ15: After a cassette stop in run mode, the cassette register is not addressable.
// RQ16: Installed size register is wired, 24 bits, low sixteen bits read zero.
// RQ17: Control group is four nibbles and an 8-bit carry, unit and length field.
// RQ18: Unit select is written only by bias; only its low bit picks packed operands.
// RQ19: Operand length is at most 24 and a multiple of the unit size; the code clamps at 24 but never checks the multiple.
// RQ20: Carry flag feeds arithmetic, is readable, writable and set by set-carry.
// RQ21: The checked field address is a 24-bit absolute bit address.
// RQ22: Parity error on a fetched microinstruction sets the read data error flag.
// RQ23: A failed write or swap without override leaves main memory unchanged.
`include "msb_map.svh"
module msb_sequencer (
  // Clock, enable and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // Mode and installed size strap
  input wire logic tape_mode_in,
  input wire logic [`MSB_ADDR_W-1:0] installed_memory_size_in,
  // Decoded microinstruction controls
  input wire msb_pkg::msb_op_t op_in,
  input wire logic op_valid_in,
  // Register move port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_sel_in,
  input wire logic [`MSB_ADDR_W-1:0] reg_wdata_in,
  output logic [`MSB_ADDR_W-1:0] reg_rdata_out,
  output logic reg_rd_stall_out,
  // Instruction fetch from main memory
  input wire logic fetch_valid_in,
  input wire logic [`MSB_WORD_W:0] fetch_word_in,
  output logic [`MSB_PC_W+`MSB_PC_SHIFT-1:0] fetch_addr_out,
  // Memory reference check
  input wire msb_pkg::msb_mem_t mem_op_in,
  input wire logic [`MSB_ADDR_W-1:0] field_address_in,
  input wire logic field_address_neg_in,
  output logic mem_write_allow_out,
  output logic memory_range_error_flag_out,
  // Cassette serial input
  input wire logic cass_bit_valid_in,
  input wire logic cass_bit_in,
  // Arithmetic unit
  input wire logic alu_carry_in,
  output logic carry_flag_out,
  output logic operand_unit_packed_out,
  output logic [4:0] operand_length_out,
  output logic [`MSB_WORD_W-1:0] micro_instruction_hold_out,
  output logic [7:0] control_nibbles_out
);
  import msb_pkg::*;

  logic [`MSB_WORD_W-1:0] mih_q;
  logic [`MSB_WORD_W-1:0] or_pend_q;
  logic [`MSB_PC_W-1:0] pc_q;
  logic [`MSB_ADDR_W-1:0] lower_q;
  logic [`MSB_ADDR_W-1:0] upper_q;
  logic [`MSB_WORD_W-1:0] cass_shift_q;
  logic [`MSB_WORD_W-1:0] cass_word_q;
  logic [4:0] cass_cnt_q;
  logic cass_full_q;
  logic cass_stopped_q;
  logic cass_consumed_q;
  logic [3:0] nib1_q;
  logic [3:0] nib2_q;
  logic [3:0] intr_q;
  logic [3:0] merr_q;
  logic carry_q;
  logic [1:0] unit_q;
  logic [4:0] oplen_q;
  logic range_err_q;
  logic fetch_parity_ok;
  logic in_bounds;
  logic is_write;
  logic cass_read;
  logic cass_addressable;
  logic [`MSB_ADDR_W-1:0] rdata_d;

  // Shared register select decode.
  function automatic logic sel_is(input logic [3:0] sel, input logic [3:0] code);
    sel_is = (sel == code);
  endfunction : sel_is

  // Program counter as seen on the data path, pre-aligned to bit addresses.
  function automatic logic [`MSB_ADDR_W-1:0] pc_view(input logic [`MSB_PC_W-1:0] pc);
    pc_view = {2'h0, pc, 4'h0}; // RQ5
  endfunction : pc_view

  assign fetch_parity_ok = ^fetch_word_in; // RQ22
  assign in_bounds = (field_address_in >= lower_q) && (field_address_in <= upper_q); // RQ6 RQ9 RQ21
  assign is_write = (mem_op_in == MSB_MEM_WRITE) || (mem_op_in == MSB_MEM_SWAP);
  // A stopped cassette makes the register vanish in run mode; tape mode keeps it live.
  assign cass_addressable = tape_mode_in || !cass_stopped_q; // RQ15
  assign cass_read = reg_rd_in && sel_is(reg_sel_in, `MSB_SEL_CASS) && cass_addressable;

  // Instruction hold: OR-merge of a moved value into the next fetched word.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mih_q <= 16'h0000;
      or_pend_q <= 16'h0000;
    end else if (clk_en_in) begin
      if (!tape_mode_in && fetch_valid_in) begin
        mih_q <= fetch_word_in[`MSB_WORD_W-1:0] | or_pend_q; // RQ1 RQ2
        or_pend_q <= 16'h0000;
      end else if (tape_mode_in && cass_full_q && !cass_consumed_q && !cass_read) begin
        mih_q <= cass_word_q | or_pend_q; // RQ12 RQ14
        or_pend_q <= 16'h0000;
      end else if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_MIH)) begin
        or_pend_q <= or_pend_q | reg_wdata_in[`MSB_WORD_W-1:0]; // RQ2 RQ14
      end
    end
  end

  // Program counter: increment per fetch, branch forward, or direct write.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_q <= 18'h00000;
    end else if (clk_en_in) begin
      if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_PC)) begin
        pc_q <= reg_wdata_in[`MSB_PC_W+`MSB_PC_SHIFT-1:`MSB_PC_SHIFT]; // RQ4 RQ5
      end else if (op_valid_in && op_in == MSB_OP_BRANCH_FWD) begin
        // Counter already names the following word; the skip adds on top and may wrap.
        pc_q <= pc_q + {6'h00, mih_q[`MSB_BRANCH_W-1:0]}; // RQ3 RQ4 RQ13
      end else if (!tape_mode_in && fetch_valid_in) begin
        pc_q <= pc_q + 18'h00001; // RQ4
      end
    end
  end

  // Bounds registers.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lower_q <= 24'h000000;
      upper_q <= 24'hFFFFFF;
    end else if (clk_en_in && reg_wr_in) begin
      if (sel_is(reg_sel_in, `MSB_SEL_LOWER)) begin
        lower_q <= reg_wdata_in;
      end
      if (sel_is(reg_sel_in, `MSB_SEL_UPPER)) begin
        upper_q <= reg_wdata_in;
      end
    end
  end

  // Cassette shifter. A finished word overwrites an unread one with no trace.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cass_shift_q <= 16'h0000;
      cass_word_q <= 16'h0000;
      cass_cnt_q <= 5'h00;
      cass_full_q <= 1'b0;
      cass_consumed_q <= 1'b0;
    end else if (clk_en_in) begin
      if (cass_bit_valid_in) begin
        if (cass_cnt_q == 5'h0F) begin
          cass_word_q <= {cass_shift_q[`MSB_WORD_W-2:0], cass_bit_in}; // RQ11
          cass_full_q <= 1'b1;
          cass_consumed_q <= 1'b0;
          cass_cnt_q <= 5'h00;
        end else begin
          cass_shift_q <= {cass_shift_q[`MSB_WORD_W-2:0], cass_bit_in};
          cass_cnt_q <= cass_cnt_q + 5'h01;
        end
      end else if (cass_read && cass_full_q) begin
        cass_full_q <= 1'b0;
        cass_consumed_q <= tape_mode_in; // RQ12
      end else if (tape_mode_in && cass_full_q) begin
        cass_full_q <= 1'b0;
      end
    end
  end

  // Cassette run/stop state.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cass_stopped_q <= 1'b0;
    end else if (clk_en_in && op_valid_in) begin
      if (op_in == MSB_OP_CASS_STOP) begin
        cass_stopped_q <= 1'b1; // RQ15
      end else if (op_in == MSB_OP_CASS_START) begin
        cass_stopped_q <= 1'b0;
      end
    end
  end

  // Control nibbles; hardware flag sets win over software writes in the same cycle.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nib1_q <= 4'h0;
      nib2_q <= 4'h0;
      intr_q <= 4'h0;
      merr_q <= 4'h0;
    end else if (clk_en_in) begin
      if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_NIB1)) begin
        nib1_q <= reg_wdata_in[3:0];
      end
      if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_NIB2)) begin
        nib2_q <= reg_wdata_in[3:0];
      end
      if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_INTR)) begin
        intr_q <= reg_wdata_in[3:0];
      end
      merr_q <= (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_MERR)) ? reg_wdata_in[3:0] : merr_q;
      if (!tape_mode_in && fetch_valid_in && !fetch_parity_ok) begin
        merr_q[`MSB_MERR_RDERR] <= 1'b1; // RQ22
      end
      if (mem_op_in == MSB_MEM_READ && !in_bounds) begin
        merr_q[`MSB_MERR_RDOOB] <= 1'b1; // RQ7
      end
      if (is_write && !in_bounds) begin
        merr_q[`MSB_MERR_WROOB] <= 1'b1; // RQ7
      end
    end
  end

  // Parallelism field: carry, unit select and operand length.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      carry_q <= 1'b0;
      unit_q <= 2'h0;
      oplen_q <= 5'h00;
    end else if (clk_en_in) begin
      if (op_valid_in && op_in == MSB_OP_SET_CARRY) begin
        carry_q <= alu_carry_in; // RQ20
      end else if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_CARRY)) begin
        carry_q <= reg_wdata_in[0]; // RQ20
      end else if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_PAR)) begin
        carry_q <= reg_wdata_in[`MSB_PAR_CARRY];
      end
      if (op_valid_in && op_in == MSB_OP_BIAS) begin
        unit_q <= reg_wdata_in[`MSB_PAR_UNIT_HI:`MSB_PAR_UNIT_LO]; // RQ18
      end
      if (reg_wr_in && sel_is(reg_sel_in, `MSB_SEL_PAR)) begin
        // Lengths past the widest operand are clamped; multiples of the unit stay firmware's job.
        oplen_q <= (reg_wdata_in[`MSB_PAR_LEN_HI:0] > `MSB_OPLEN_MAX) ?
                   `MSB_OPLEN_MAX : reg_wdata_in[`MSB_PAR_LEN_HI:0]; // RQ17 RQ19
      end
    end
  end

  // Read data mux; unit select is write-only and reads as zero.
  always_comb begin
    rdata_d = 24'h000000;
    case (reg_sel_in)
      `MSB_SEL_MIH: rdata_d = {8'h00, mih_q};
      `MSB_SEL_PC: rdata_d = pc_view(pc_q); // RQ5
      `MSB_SEL_LOWER: rdata_d = lower_q;
      `MSB_SEL_UPPER: rdata_d = upper_q;
      `MSB_SEL_CASS: rdata_d = cass_addressable ? {8'h00, cass_word_q} : 24'h000000; // RQ11
      `MSB_SEL_SIZE: rdata_d = {installed_memory_size_in[23:16], 16'h0000}; // RQ16
      `MSB_SEL_NIB1: rdata_d = {20'h00000, nib1_q};
      `MSB_SEL_NIB2: rdata_d = {20'h00000, nib2_q};
      `MSB_SEL_INTR: rdata_d = {20'h00000, intr_q};
      `MSB_SEL_MERR: rdata_d = {20'h00000, merr_q};
      `MSB_SEL_PAR: rdata_d = {16'h0000, carry_q, 2'h0, oplen_q};
      `MSB_SEL_CARRY: rdata_d = {23'h000000, carry_q};
      default: rdata_d = 24'h000000;
    endcase
  end

  // Registered outputs.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 24'h000000;
      reg_rd_stall_out <= 1'b0;
      fetch_addr_out <= 22'h000000;
      mem_write_allow_out <= 1'b0;
      memory_range_error_flag_out <= 1'b0;
      range_err_q <= 1'b0;
    end else if (clk_en_in) begin
      reg_rdata_out <= rdata_d;
      reg_rd_stall_out <= cass_read && !cass_full_q && !tape_mode_in; // RQ11
      fetch_addr_out <= {pc_q, 4'h0}; // RQ5
      mem_write_allow_out <= is_write && (in_bounds || merr_q[`MSB_MERR_OVR]); // RQ8 RQ23
      range_err_q <= (mem_op_in != MSB_MEM_IDLE) && (field_address_neg_in ||
                     field_address_in > installed_memory_size_in); // RQ10
      memory_range_error_flag_out <= (mem_op_in != MSB_MEM_IDLE) && (field_address_neg_in ||
                     field_address_in > installed_memory_size_in); // RQ10
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      carry_flag_out <= 1'b0;
      operand_unit_packed_out <= 1'b0;
      operand_length_out <= 5'h00;
      micro_instruction_hold_out <= 16'h0000;
      control_nibbles_out <= 8'h00;
    end else if (clk_en_in) begin
      carry_flag_out <= carry_q; // RQ20
      operand_unit_packed_out <= unit_q[0]; // RQ18
      operand_length_out <= oplen_q;
      micro_instruction_hold_out <= mih_q; // RQ1
      control_nibbles_out <= {intr_q, merr_q};
    end
  end

  wr_block_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && is_write && !in_bounds && !merr_q[`MSB_MERR_OVR] |=> !mem_write_allow_out)
    else $error("Out-of-bounds write allowed without override."); // RQ23
  rd_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && mem_op_in == MSB_MEM_READ && !in_bounds |=> merr_q[`MSB_MERR_RDOOB])
    else $error("Read out of bounds not flagged."); // RQ7
  wr_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && is_write && !in_bounds |=> merr_q[`MSB_MERR_WROOB])
    else $error("Write out of bounds not flagged."); // RQ7
  pc_inc_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && !tape_mode_in && fetch_valid_in && !reg_wr_in && !op_valid_in
    |=> pc_q == $past(pc_q) + 18'h00001)
    else $error("Counter did not step on fetch."); // RQ4
  pc_align_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in ##1 clk_en_in |=> fetch_addr_out[3:0] == 4'h0)
    else $error("Counter view not aligned."); // RQ5
  or_merge_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && !tape_mode_in && fetch_valid_in
    |=> mih_q == ($past(fetch_word_in[15:0]) | $past(or_pend_q)))
    else $error("Fetched word not merged."); // RQ2
  size_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && reg_sel_in == `MSB_SEL_SIZE |=> reg_rdata_out[15:0] == 16'h0000)
    else $error("Size register low bits not zero."); // RQ16
  parity_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && !tape_mode_in && fetch_valid_in && !(^fetch_word_in)
    |=> merr_q[`MSB_MERR_RDERR])
    else $error("Fetch parity error not flagged."); // RQ22
  len_max_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    oplen_q <= `MSB_OPLEN_MAX)
    else $error("Operand length above limit."); // RQ19
  range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    clk_en_in && mem_op_in != MSB_MEM_IDLE && field_address_neg_in
    |=> memory_range_error_flag_out && range_err_q)
    else $error("Range error output disagrees."); // RQ10
endmodule : msb_sequencer

// [tb/msb_far_side.sv]
// Far-side model of main memory answering fetches and of the console cassette shifting words in.
module msb_far_side (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Fetch requests from the bench
  input wire logic [21:0] fetch_addr_in,
  input wire logic fetch_go_in,
  input wire logic [1:0] fetch_lat_in,
  input wire logic bad_parity_in,
  // Cassette requests from the bench
  input wire logic cass_go_in,
  input wire logic [15:0] cass_word_in,
  // Toward the sequencer
  output logic fetch_valid_out,
  output logic [16:0] fetch_word_out,
  output logic cass_bit_valid_out,
  output logic cass_bit_out
);
  logic busy_q;
  logic [1:0] lat_q;
  logic [15:0] word;
  logic [15:0] shift_q;
  logic [5:0] cnt_q;
  // Each word is a branch-forward shape whose count is the low nibble of its own index.
  assign word = {12'hC00, fetch_addr_in[7:4]};
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_q <= 1'b0;
      lat_q <= 2'h0;
      fetch_valid_out <= 1'b0;
      fetch_word_out <= 17'h00000;
    end else begin
      fetch_valid_out <= 1'b0;
      // A released bus never keeps the last word, so stale data cannot pass for a fetch.
      fetch_word_out <= ~fetch_word_out;
      if (fetch_go_in) begin
        busy_q <= 1'b1;
        lat_q <= fetch_lat_in;
      end else if (busy_q && lat_q != 2'h0) begin
        lat_q <= lat_q - 2'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        fetch_valid_out <= 1'b1;
        fetch_word_out <= {(~^word) ^ bad_parity_in, word};
      end
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 6'h00;
      shift_q <= 16'h0000;
      cass_bit_valid_out <= 1'b0;
      cass_bit_out <= 1'b0;
    end else begin
      cass_bit_valid_out <= 1'b0;
      cass_bit_out <= ~cass_bit_out;
      if (cass_go_in) begin
        shift_q <= cass_word_in;
        cnt_q <= 6'h20;
      end else if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
        if (!cnt_q[0]) begin
          cass_bit_valid_out <= 1'b1;
          cass_bit_out <= shift_q[15];
          shift_q <= {shift_q[14:0], 1'b0};
        end
      end
    end
  end
endmodule : msb_far_side

// [tb/tb_msb_sequencer.sv]
// Self-checking bench for the micro sequencer: register moves, fetch, bounds and cassette.
`include "msb_map.svh"
module tb_msb_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import msb_pkg::*;
  localparam int DLY = 5;
  localparam logic [31:0] BTAB [9] = '{32'h40000100, 32'h40000200, 32'h440000FF,
    32'h44000201, 32'h90000200, 32'h88000201, 32'hBA000201, 32'hC80000FF, 32'hD0000100};
  logic sys_clk, rst_b, tape, reg_wr, reg_rd, fa_neg, alu_c, op_valid;
  logic fetch_go, bad_par, cass_go, fetch_valid, cass_v, cass_b, allow, rng;
  logic stall, carry, pkd, range_err, wr_allow;
  logic [3:0] reg_sel;
  logic [1:0] fetch_lat;
  logic [15:0] cass_word, mih;
  logic [16:0] fetch_word;
  logic [21:0] fetch_addr;
  logic [23:0] reg_wdata, fa, rdata;
  logic [4:0] oplen;
  logic [7:0] nibs;
  msb_op_t op;
  msb_mem_t mem_op;
  int fail_count, comparisons;
  msb_sequencer u_msb_sequencer (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .clk_en_in(1'b1),
    .tape_mode_in(tape), .installed_memory_size_in(24'h02ABCD), .op_in(op),
    .op_valid_in(op_valid), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_sel_in(reg_sel),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata), .reg_rd_stall_out(stall),
    .fetch_valid_in(fetch_valid), .fetch_word_in(fetch_word), .fetch_addr_out(fetch_addr),
    .mem_op_in(mem_op), .field_address_in(fa), .field_address_neg_in(fa_neg),
    .mem_write_allow_out(wr_allow), .memory_range_error_flag_out(range_err),
    .cass_bit_valid_in(cass_v), .cass_bit_in(cass_b), .alu_carry_in(alu_c),
    .carry_flag_out(carry), .operand_unit_packed_out(pkd), .operand_length_out(oplen),
    .micro_instruction_hold_out(mih), .control_nibbles_out(nibs));
  msb_far_side u_msb_far_side (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .fetch_addr_in(fetch_addr), .fetch_go_in(fetch_go), .fetch_lat_in(fetch_lat),
    .bad_parity_in(bad_par), .cass_go_in(cass_go), .cass_word_in(cass_word),
    .fetch_valid_out(fetch_valid), .fetch_word_out(fetch_word),
    .cass_bit_valid_out(cass_v), .cass_bit_out(cass_b));
  always #50 sys_clk = ~sys_clk;
  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #DLY;
  endtask : step
  task automatic wr(input logic [3:0] sel, input logic [23:0] d);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [3:0] sel, input logic [23:0] exp);
    reg_rd = 1'b1;
    reg_sel = sel;
    step(1);
    chk(rdata, exp);
    reg_rd = 1'b0;
    step(1);
  endtask : rd
  task automatic do_op(input msb_op_t o, input logic [23:0] d);
    op = o;
    reg_wdata = d;
    op_valid = 1'b1;
    step(1);
    op_valid = 1'b0;
    step(1);
  endtask : do_op
  task automatic mem_ref(input msb_mem_t m, input logic [23:0] a, input logic n);
    mem_op = m;
    fa = a;
    fa_neg = n;
    step(2);
    allow = wr_allow;
    rng = range_err;
    mem_op = MSB_MEM_IDLE;
    step(1);
  endtask : mem_ref
  task automatic fetch(input logic [1:0] lat, input logic bad);
    fetch_lat = lat;
    bad_par = bad;
    fetch_go = 1'b1;
    step(1);
    fetch_go = 1'b0;
    for (int i = 0; i < 8 && fetch_valid !== 1'b1; i++) step(1);
    chk(24'(fetch_valid), 24'h000001);
    // The hold register is copied to its output one edge after the fetch lands.
    step(2);
  endtask : fetch
  task automatic cass(input logic [15:0] w);
    cass_word = w;
    cass_go = 1'b1;
    step(1);
    cass_go = 1'b0;
    step(40);
  endtask : cass
  initial begin
    {sys_clk, rst_b, tape, reg_wr, reg_rd, fa_neg, alu_c, op_valid} = 8'h00;
    {fetch_go, bad_par, cass_go, reg_sel, fetch_lat, cass_word, reg_wdata, fa} = '0;
    op = MSB_OP_NONE;
    mem_op = MSB_MEM_IDLE;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge sys_clk);
    #DLY;
    rst_b = 1'b1;
    step(1);
    rd(`MSB_SEL_UPPER, 24'hFFFFFF);
    rd(`MSB_SEL_LOWER, 24'h000000);
    rd(`MSB_SEL_SIZE, 24'h020000);
    wr(`MSB_SEL_NIB1, 24'h000005);
    rd(`MSB_SEL_NIB1, 24'h000005);
    wr(`MSB_SEL_NIB2, 24'h00000A);
    rd(`MSB_SEL_NIB2, 24'h00000A);
    wr(`MSB_SEL_INTR, 24'h000003);
    chk(24'(nibs), 24'h000030);
    wr(`MSB_SEL_PC, 24'h000000);
    wr(`MSB_SEL_MIH, 24'h000002);
    fetch(2'h0, 1'b0);
    chk(24'(mih), 24'h00C002);
    do_op(MSB_OP_BRANCH_FWD, 24'h000000);
    rd(`MSB_SEL_PC, 24'h000030);
    fetch(2'h3, 1'b0);
    chk(24'(mih), 24'h00C003);
    rd(`MSB_SEL_PC, 24'h000040);
    wr(`MSB_SEL_PC, 24'hFFFFF7);
    rd(`MSB_SEL_PC, 24'h3FFFF0);
    fetch(2'h1, 1'b0);
    rd(`MSB_SEL_PC, 24'h000000);
    chk(24'(fetch_addr), 24'h000000);
    wr(`MSB_SEL_MERR, 24'h000000);
    fetch(2'h0, 1'b1);
    chk(24'(nibs[0]), 24'h000001);
    wr(`MSB_SEL_LOWER, 24'h000100);
    wr(`MSB_SEL_UPPER, 24'h000200);
    foreach (BTAB[i]) begin
      wr(`MSB_SEL_MERR, {22'h0, BTAB[i][29], 1'b0});
      mem_ref(msb_mem_t'(BTAB[i][31:30]), BTAB[i][23:0], 1'b0);
      if (BTAB[i][31]) chk(24'(allow), 24'(BTAB[i][28]));
      chk(24'(nibs[3:0]), 24'(BTAB[i][27:24]));
    end
    mem_ref(MSB_MEM_READ, 24'h000150, 1'b1);
    chk(24'(rng), 24'h000001);
    mem_ref(MSB_MEM_READ, 24'hFFFFFF, 1'b0);
    chk(24'(rng), 24'h000001);
    mem_ref(MSB_MEM_READ, 24'h000150, 1'b0);
    chk(24'(rng), 24'h000000);
    wr(`MSB_SEL_PAR, 24'h00001F);
    chk(24'(oplen), 24'h000018);
    rd(`MSB_SEL_PAR, 24'h000018);
    do_op(MSB_OP_BIAS, 24'h000020);
    chk(24'(pkd), 24'h000001);
    do_op(MSB_OP_BIAS, 24'h000040);
    chk(24'(pkd), 24'h000000);
    do_op(MSB_OP_BIAS, 24'h000020);
    wr(`MSB_SEL_PAR, 24'h000048);
    chk(24'(pkd), 24'h000001);
    chk(24'(oplen), 24'h000008);
    wr(`MSB_SEL_CARRY, 24'h000001);
    rd(`MSB_SEL_CARRY, 24'h000001);
    do_op(MSB_OP_SET_CARRY, 24'h000000);
    chk(24'(carry), 24'h000000);
    alu_c = 1'b1;
    do_op(MSB_OP_SET_CARRY, 24'h000000);
    chk(24'(carry), 24'h000001);
    cass_word = 16'hA5C3;
    cass_go = 1'b1;
    reg_rd = 1'b1;
    reg_sel = `MSB_SEL_CASS;
    step(1);
    chk(24'(stall), 24'h000001);
    {cass_go, reg_rd} = 2'b00;
    step(40);
    rd(`MSB_SEL_CASS, 24'h00A5C3);
    cass(16'h1234);
    do_op(MSB_OP_CASS_STOP, 24'h000000);
    rd(`MSB_SEL_CASS, 24'h000000);
    do_op(MSB_OP_CASS_START, 24'h000000);
    tape = 1'b1;
    step(1);
    wr(`MSB_SEL_MIH, 24'h000002);
    cass(16'hC000);
    chk(24'(mih), 24'h00C002);
    wr(`MSB_SEL_PC, 24'h001000);
    do_op(MSB_OP_BRANCH_FWD, 24'h000000);
    rd(`MSB_SEL_PC, 24'h001020);
    print_verdict();
  end
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_msb_sequencer
